// ===== verilog/gate_drive_consts.svh
// timing and reset constants for the gate driver host controller
`ifndef GATE_DRIVE_CONSTS_SVH
`define GATE_DRIVE_CONSTS_SVH

`define GDH_CLK_PERIOD_NS    5
`define GDH_DEGLITCH_NS      40
// hold each pin level strictly longer than the deglitch window
`define GDH_MIN_PULSE_CYC    ((`GDH_DEGLITCH_NS + `GDH_CLK_PERIOD_NS - 1) / `GDH_CLK_PERIOD_NS + 1)
`define GDH_FAULT_MUTE_NS    1000
`define GDH_FAULT_MUTE_CYC   ((`GDH_FAULT_MUTE_NS + `GDH_CLK_PERIOD_NS - 1) / `GDH_CLK_PERIOD_NS)
`define GDH_RST_FILTER_NS    1000
`define GDH_RST_FILTER_CYC   ((`GDH_RST_FILTER_NS + `GDH_CLK_PERIOD_NS - 1) / `GDH_CLK_PERIOD_NS)
`define GDH_RECOVER_CYC      64
`define GDH_CNT_W            16
`define GDH_PINS_RESET       3'h0

`endif

// ===== verilog/gate_drive_pkg.sv
// types shared by the gate driver host controller
package gate_drive_pkg;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'h01,
		ST_RUN     = 5'h02,
		ST_MUTE    = 5'h04,
		ST_CLEAR   = 5'h08,
		ST_RECOVER = 5'h10
	} host_state_e;

	typedef struct packed {
		logic in_pos;
		logic in_neg;
		logic rst_en;
	} pin_req_s;

endpackage

// ===== verilog/pin_pulse_hold.sv
// holds each driven pin level for a least number of cycles
module pin_pulse_hold #(
	parameter int HOLD_CYC = 9,
	parameter int CNT_W    = 16
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic req_i,
	output logic      pin_o
);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             next_pin;

	if (CNT_W < 2 || CNT_W > 30) begin : g_bad_cnt_w
		$error("pin_pulse_hold: CNT_W out of range");
	end
	if (HOLD_CYC < 1 || HOLD_CYC >= (1 << CNT_W)) begin : g_bad_hold
		$error("pin_pulse_hold: HOLD_CYC out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_pin = pin_o;
		next_cnt = cnt;
		if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end else if (req_i != pin_o) begin
			next_pin = req_i;
			next_cnt = CNT_W'(HOLD_CYC - 1);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_o <= 1'b0;
			cnt   <= '0;
		end else begin
			pin_o <= next_pin;
			cnt   <= next_cnt;
		end
	end

endmodule

// ===== verilog/gate_drive_host.sv
// host controller driving the isolated gate driver input pins
`include "gate_drive_consts.svh"

module gate_drive_host
	import gate_drive_pkg::*;
#(
	parameter int MUTE_CYC    = `GDH_FAULT_MUTE_CYC,
	parameter int RST_LOW_CYC = `GDH_RST_FILTER_CYC + `GDH_MIN_PULSE_CYC,
	parameter int RECOVER_CYC = `GDH_RECOVER_CYC,
	parameter int PULSE_CYC   = `GDH_MIN_PULSE_CYC,
	parameter int CNT_W       = `GDH_CNT_W
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic enable_i,
	input  wire logic pwm_i,
	input  wire logic pwm_other_i,
	input  wire logic interlock_en_i,
	input  wire logic inverting_i,
	input  wire logic auto_clear_i,
	input  wire logic fault_clear_i,
	input  wire logic fault_flag_out_n_i,
	input  wire logic ready_i,
	output logic      in_pos_o,
	output logic      in_neg_o,
	output logic      rst_en_o,
	output logic      fault_o,
	output logic      ready_o,
	output logic      running_o
);

	host_state_e      state;
	host_state_e      next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             clr_req;
	logic             next_clr_req;
	logic             next_fault;
	logic             next_ready;
	logic             next_running;
	pin_req_s         pins;

	////////////////////////////////////////////////////////////////////////////////
	// parameter checks at elaboration
	if (CNT_W < 2 || CNT_W > 30) begin : g_bad_cnt_w
		$error("gate_drive_host: CNT_W out of range");
	end
	if (MUTE_CYC < 1 || MUTE_CYC >= (1 << CNT_W)) begin : g_bad_mute
		$error("gate_drive_host: MUTE_CYC out of range");
	end
	if (RST_LOW_CYC < 1 || RST_LOW_CYC >= (1 << CNT_W)) begin : g_bad_rst_low
		$error("gate_drive_host: RST_LOW_CYC out of range");
	end
	if (RECOVER_CYC < 1 || RECOVER_CYC >= (1 << CNT_W)) begin : g_bad_recover
		$error("gate_drive_host: RECOVER_CYC out of range");
	end
	if (PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W)) begin : g_bad_pulse
		$error("gate_drive_host: PULSE_CYC out of range");
	end
	if (RST_LOW_CYC <= PULSE_CYC) begin : g_bad_rst_pulse
		$error("gate_drive_host: RST_LOW_CYC must exceed PULSE_CYC");
	end

	function automatic logic [CNT_W-1:0] load_cnt(input int cyc);
		load_cnt = CNT_W'(cyc - 1);
	endfunction

	function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] val);
		count_down = val - 1'b1;
	endfunction

	function automatic logic cnt_done(input logic [CNT_W-1:0] val);
		cnt_done = (val == '0);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// fault sequencing
	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_fault   = fault_o;
		next_clr_req = clr_req | fault_clear_i;
		next_ready   = ready_i;
		case (state)
			ST_IDLE: begin
				if (enable_i) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!fault_flag_out_n_i) begin
					next_state   = ST_MUTE;
					next_cnt     = load_cnt(MUTE_CYC);
					next_fault   = 1'b1;
					next_clr_req = fault_clear_i;
				end else if (!enable_i) begin
					next_state = ST_IDLE;
				end
			end
			ST_MUTE: begin
				if (!cnt_done(cnt)) begin
					next_cnt = count_down(cnt);
				end else if (auto_clear_i || clr_req) begin
					next_state   = ST_CLEAR;
					next_cnt     = load_cnt(RST_LOW_CYC);
					next_clr_req = fault_clear_i;
				end
			end
			ST_CLEAR: begin
				if (!cnt_done(cnt)) begin
					next_cnt = count_down(cnt);
				end else begin
					next_state = ST_RECOVER;
					next_cnt   = load_cnt(RECOVER_CYC);
				end
			end
			ST_RECOVER: begin
				if (fault_flag_out_n_i) begin
					next_fault = 1'b0;
					next_state = enable_i ? ST_RUN : ST_IDLE;
				end else if (cnt_done(cnt)) begin
					next_state = ST_MUTE;
					next_cnt   = load_cnt(MUTE_CYC);
				end else begin
					next_cnt = count_down(cnt);
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_running = (next_state == ST_RUN);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state     <= ST_IDLE;
			cnt       <= '0;
			clr_req   <= 1'b0;
			fault_o   <= 1'b0;
			ready_o   <= 1'b0;
			running_o <= 1'b0;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			clr_req   <= next_clr_req;
			fault_o   <= next_fault;
			ready_o   <= next_ready;
			running_o <= next_running;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin levels requested from the state
	always_comb begin
		pins.in_pos = 1'b0;
		pins.in_neg = 1'b0;
		pins.rst_en = 1'b0;
		case (state)
			ST_RUN: begin
				if (inverting_i) begin
					pins.in_pos = 1'b1;
					pins.in_neg = ~pwm_i;
					pins.rst_en = auto_clear_i ? pwm_i : 1'b1;
				end else begin
					pins.in_pos = pwm_i;
					pins.in_neg = interlock_en_i & pwm_other_i;
					pins.rst_en = auto_clear_i ? pwm_i : 1'b1;
				end
			end
			ST_MUTE, ST_RECOVER: begin
				pins.rst_en = 1'b1;
			end
			ST_CLEAR: begin
				pins.rst_en = 1'b0;
			end
			default: begin
				pins.rst_en = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// every pin level outlasts the input deglitch window
	pin_pulse_hold #(.HOLD_CYC(PULSE_CYC), .CNT_W(CNT_W)) u_hold_pos (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.req_i  (pins.in_pos),
		.pin_o  (in_pos_o)
	);

	pin_pulse_hold #(.HOLD_CYC(PULSE_CYC), .CNT_W(CNT_W)) u_hold_neg (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.req_i  (pins.in_neg),
		.pin_o  (in_neg_o)
	);

	pin_pulse_hold #(.HOLD_CYC(PULSE_CYC), .CNT_W(CNT_W)) u_hold_rst (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.req_i  (pins.rst_en),
		.pin_o  (rst_en_o)
	);

endmodule

// ===== verif/gate_device_model.sv
// behavioural model of the gate driver input side
module gate_device_model (
	input  wire logic       clk_i,
	input  wire logic       inject_i,
	input  wire logic [2:0] pins_i,
	output logic            flag_n_o,
	output logic            gate_o,
	output logic            pull_down_output_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] filt = 3'h0;
	logic [3:0] age [3] = '{4'h0, 4'h0, 4'h0};
	logic [3:0] low = 4'h0;
	logic       lat = 1'b0;
	always @(posedge clk_i) begin
		for (int k = 0; k < 3; k++) begin
			age[k] <= (pins_i[k] === filt[k]) ? 4'h0 : age[k] + 4'h1;
			if (age[k] == 4'h8) filt[k] <= pins_i[k] === 1'b1;
		end
		low <= filt[2] ? 4'h0 : low + {3'h0, !low[3]};
		if (inject_i) lat <= 1'b1;
		else if (filt[2] && low > 4'h3) lat <= 1'b0;
	end
	assign flag_n_o = lat ? 1'b0 : 1'b1;
	assign gate_o = filt[0] && !filt[1] && filt[2] && !lat;
	assign pull_down_output_o = !gate_o;
endmodule

// ===== verif/gate_drive_host_monitor.sv
// port assertions for the gate driver host controller
module gate_drive_host_monitor (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic pwm_i,
	input wire logic pwm_other_i,
	input wire logic inverting_i,
	input wire logic fault_flag_out_n_i,
	input wire logic in_pos_o,
	input wire logic in_neg_o,
	input wire logic rst_en_o,
	input wire logic fault_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence flt_up; $rose(fault_o); endsequence
	a_fault_cause: assert property (flt_up |-> !$past(fault_flag_out_n_i))
		else $error("fault");
	a_fault_pins: assert property (flt_up |-> ##[0:10] (!in_pos_o && !in_neg_o))
		else $error("pins");
	a_mute_wait: assert property (flt_up and rst_en_o |-> rst_en_o[*4])
		else $error("mute");
	a_clear_low: assert property ($fell(rst_en_o) && fault_o |-> !rst_en_o[*8])
		else $error("reset");
	a_flag_clear: assert property ($fell(fault_o) |-> $past(fault_flag_out_n_i))
		else $error("clear");
	a_pin_hold: assert property ($changed(in_pos_o) |=> $stable(in_pos_o)[*8])
		else $error("pulse");
	a_pos_cause: assert property ($rose(in_pos_o) && !inverting_i |-> $past(pwm_i))
		else $error("pos");
	a_neg_cause:
		assert property ($rose(in_neg_o) |->
			($past(inverting_i) ? !$past(pwm_i) : $past(pwm_other_i)))
		else $error("neg");
endmodule
bind gate_drive_host gate_drive_host_monitor mon (
	.clk_i              (clk_i),
	.rstn_i             (rstn_i),
	.pwm_i              (pwm_i),
	.pwm_other_i        (pwm_other_i),
	.inverting_i        (inverting_i),
	.fault_flag_out_n_i (fault_flag_out_n_i),
	.in_pos_o           (in_pos_o),
	.in_neg_o           (in_neg_o),
	.rst_en_o           (rst_en_o),
	.fault_o            (fault_o)
);

// ===== verif/gate_drive_host_tb.sv
// self-checking bench for the gate driver host controller
module gate_drive_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rstn_i = 1'b0, enable_i = 1'b0, pwm_i = 1'b0, pwm_other_i = 1'b0;
	logic interlock_en_i = 1'b0, inverting_i = 1'b0, auto_clear_i = 1'b0, ready_i = 1'b1;
	logic fault_clear_i = 1'b0, inj = 1'b0, gate, pull_down, fault_flag_out_n_i;
	logic in_pos_o, in_neg_o, rst_en_o, fault_o, ready_o, running_o;
	int   num_errors = 0, check_count = 0;
	gate_drive_host #(.MUTE_CYC(4), .RST_LOW_CYC(12), .RECOVER_CYC(20)) DUT (
		.clk_i              (clk_i),
		.rstn_i             (rstn_i),
		.enable_i           (enable_i),
		.pwm_i              (pwm_i),
		.pwm_other_i        (pwm_other_i),
		.interlock_en_i     (interlock_en_i),
		.inverting_i        (inverting_i),
		.auto_clear_i       (auto_clear_i),
		.fault_clear_i      (fault_clear_i),
		.fault_flag_out_n_i (fault_flag_out_n_i),
		.ready_i            (ready_i),
		.in_pos_o           (in_pos_o),
		.in_neg_o           (in_neg_o),
		.rst_en_o           (rst_en_o),
		.fault_o            (fault_o),
		.ready_o            (ready_o),
		.running_o          (running_o)
	);
	gate_device_model dev (.clk_i(clk_i), .inject_i(inj), .pins_i({rst_en_o, in_neg_o, in_pos_o}),
		.flag_n_o(fault_flag_out_n_i), .gate_o(gate), .pull_down_output_o(pull_down));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %b want %b", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_fault(input logic v);
		for (int i = 0; i < 99 && fault_o !== v; i++) cyc(1);
	endtask
	task automatic run_test;
		@(posedge clk_i) enable_i <= 1'b1;
		@(posedge clk_i) pwm_i <= 1'b1;
		cyc(24);
		chk(running_o, 1'b1);
		chk(rst_en_o, 1'b1);
		chk(in_pos_o, 1'b1);
		chk(gate, 1'b1);
		chk(pull_down, 1'b0);
		@(posedge clk_i) ready_i <= 1'b0;
		cyc(2);
		chk(ready_o, 1'b0);
		@(posedge clk_i) ready_i <= 1'b1;
		cyc(2);
		chk(ready_o, 1'b1);
		@(posedge clk_i) pwm_other_i <= 1'b1;
		@(posedge clk_i) interlock_en_i <= 1'b1;
		cyc(24);
		chk(in_neg_o, 1'b1);
		chk(gate, 1'b0);
		chk(pull_down, 1'b1);
		@(posedge clk_i) interlock_en_i <= 1'b0;
	endtask
	task automatic fault_test(input logic aut);
		@(posedge clk_i) auto_clear_i <= aut;
		cyc(24);
		@(posedge clk_i) inj <= 1'b1;
		@(posedge clk_i) inj <= 1'b0;
		wait_fault(1'b1);
		chk(fault_o, 1'b1);
		cyc(12);
		chk(in_pos_o, 1'b0);
		chk(fault_o, 1'b1);
		chk(gate, 1'b0);
		chk(rst_en_o, !aut);
		if (!aut) @(posedge clk_i) fault_clear_i <= 1'b1;
		if (!aut) @(posedge clk_i) fault_clear_i <= 1'b0;
		wait_fault(1'b0);
		chk(fault_o, 1'b0);
		cyc(24);
		chk(running_o, 1'b1);
		chk(in_pos_o, 1'b1);
		chk(gate, 1'b1);
		@(posedge clk_i) auto_clear_i <= 1'b0;
	endtask
	task automatic invert_test;
		@(posedge clk_i) inverting_i <= 1'b1;
		@(posedge clk_i) pwm_i <= 1'b0;
		cyc(24);
		chk(in_pos_o, 1'b1);
		chk(in_neg_o, 1'b1);
		chk(gate, 1'b0);
		@(posedge clk_i) auto_clear_i <= 1'b1;
		cyc(24);
		chk(rst_en_o, 1'b0);
		@(posedge clk_i) pwm_i <= 1'b1;
		cyc(24);
		chk(rst_en_o, 1'b1);
		chk(in_neg_o, 1'b0);
		chk(gate, 1'b1);
		@(posedge clk_i) enable_i <= 1'b0;
		cyc(24);
		chk(rst_en_o, 1'b0);
		chk(running_o, 1'b0);
		chk(gate, 1'b0);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		run_test();
		fault_test(1'b0);
		fault_test(1'b1);
		invert_test();
		final_report();
	end
	initial begin
		#20000;
		num_errors++;
		final_report();
	end
endmodule
